/* bench/serial_port_baud_and_receive_tb.sv */
`timescale 1ns/1ps
module serial_port_baud_and_receive_tb;
    localparam logic [11:0] A_ICTL = spbr_pkg::ADDR_INTERRUPT_CONTROL;
    localparam logic [11:0] A_FLG = spbr_pkg::ADDR_PERIPHERAL_FLAGS;
    localparam logic [11:0] A_RCS = spbr_pkg::ADDR_RECEIVE_STATUS_CONTROL;
    localparam logic [11:0] A_DAT = spbr_pkg::ADDR_RECEIVE_DATA;
    localparam logic [11:0] A_PIE = spbr_pkg::ADDR_PERIPHERAL_ENABLES;
    localparam logic [11:0] A_TSC = spbr_pkg::ADDR_TRANSMIT_STATUS_CONTROL;
    localparam logic [11:0] A_BD = spbr_pkg::ADDR_BAUD_DIVISOR;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic sleep_mode = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rx_data_in;
    logic sclk_out;
    logic sclk_oe;
    logic receive_irq;
    logic sclk_d = 1'b0;
    logic err = 1'b0;
    int n_fall = 0;
    int base = 0;
    int n_fail = 0;
    int total_checks = 0;
    logic [11:0] ra [7] = '{A_TSC, A_BD, A_RCS, A_FLG, A_DAT, A_PIE, A_ICTL};
    logic [7:0] rv [7] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    always #10 pclk = ~pclk;

    spbr_top u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleep_mode(sleep_mode), .rx_data_in(rx_data_in),
        .sclk_out(sclk_out), .sclk_oe(sclk_oe), .receive_irq(receive_irq)
    );

    spbr_peer u_peer (.pclk(pclk), .sclk_in(sclk_out), .rx_out(rx_data_in));

    always @(posedge pclk) begin
        sclk_d <= sclk_out;
        if (sclk_d && !sclk_out) n_fall <= n_fall + 1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                       output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] v;
        apb(1'b1, a, d, v);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] v;
        apb(1'b0, a, 8'h0, v);
        chk(v, exp);
    endtask

    task automatic wait_rx;
        logic [31:0] v;
        v = 32'h0;
        for (int i = 0; i < 600 && v[5] !== 1'b1; i++) apb(1'b0, A_FLG, 8'h0, v);
    endtask

    task automatic done(input string name);
        $display("test %s done", name);
    endtask

    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) rd(ra[i], {24'h0, rv[i]});
        wr(A_FLG, 8'hff);
        rd(A_FLG, 32'h0);
        wr(A_PIE, 8'hff);
        rd(A_PIE, 32'h7f);
        wr(A_TSC, 8'hff);
        rd(A_TSC, 32'hf7);
        wr(A_ICTL, 8'hc0);
        rd(A_ICTL, 32'hc0);
        pstrb <= 4'he;
        wr(A_BD, 8'h5a);
        pstrb <= 4'hf;
        rd(A_BD, 32'h0);
        rd(12'h004, 32'h0);
        chk({31'h0, err}, 32'h1);
        done("registers");
        wr(A_PIE, 8'h00);
        wr(A_BD, 8'h01);
        wr(A_TSC, 8'h00);
        wr(A_RCS, 8'h80);
        wr(A_RCS, 8'h90);
        u_peer.send(9'h05a, 8, 128);
        wait_rx();
        chk({31'h0, receive_irq}, 32'h0);
        wr(A_PIE, 8'h20);
        @(posedge pclk);
        chk({31'h0, receive_irq}, 32'h1);
        rd(A_FLG, 32'h20);
        rd(A_DAT, 32'h5a);
        rd(A_FLG, 32'h0);
        chk({31'h0, receive_irq}, 32'h0);
        done("async low speed");
        wr(A_BD, 8'h01);
        wr(A_TSC, 8'h04);
        wr(A_RCS, 8'hd0);
        u_peer.send(9'h1a5, 9, 32);
        u_peer.send(9'h03c, 9, 32);
        rd(A_RCS, 32'hd1);
        rd(A_DAT, 32'ha5);
        rd(A_RCS, 32'hd0);
        rd(A_DAT, 32'h3c);
        done("async nine bit");
        wr(A_RCS, 8'h80);
        wr(A_BD, 8'h03);
        wr(A_TSC, 8'h90);
        @(posedge pclk);
        chk({31'h0, sclk_oe}, 32'h1);
        u_peer.sync_q.push_back(9'h0c3);
        sleep_mode <= 1'b1;
        base = n_fall;
        wr(A_RCS, 8'ha0);
        repeat (100) @(posedge pclk);
        chk(n_fall - base, 32'h0);
        sleep_mode <= 1'b0;
        wait_rx();
        repeat (100) @(posedge pclk);
        chk(n_fall - base, 32'h8);
        rd(A_RCS, 32'h80);
        rd(A_DAT, 32'hc3);
        done("sync single");
        base = n_fall;
        u_peer.sync_q.push_back(9'h011);
        u_peer.sync_q.push_back(9'h022);
        u_peer.sync_q.push_back(9'h033);
        wr(A_RCS, 8'hb0);
        for (int i = 0; i < 3000 && n_fall - base < 24; i++) @(posedge pclk);
        repeat (300) @(posedge pclk);
        chk(n_fall - base, 32'h18);
        rd(A_RCS, 32'hb2);
        rd(A_DAT, 32'h11);
        rd(A_DAT, 32'h22);
        wr(A_RCS, 8'h80);
        rd(A_RCS, 32'h80);
        done("sync overrun");
        end_sim();
    end

    // The sequence needs roughly three thousand cycles; allow about fifteen times that
    initial begin
        #1_000_000;
        n_fail++;
        end_sim();
    end
endmodule // serial_port_baud_and_receive_tb

/* bench/spbr_peer.sv */
`timescale 1ns/1ps
module spbr_peer (
    input wire logic pclk,
    input wire logic sclk_in,
    output logic rx_out
);
    logic [8:0] sync_q [$];
    logic [8:0] sh = 9'h0;
    logic sclk_d = 1'b0;
    int nleft = 0;

    // Line idles high through its pull-up
    initial rx_out = 1'b1;

    // Asynchronous frame, LSB first; a one-cycle spike mid-bit hits at most one vote
    task automatic send(input logic [8:0] w, input int nb, input int per);
        logic b;
        for (int i = 0; i < nb + 2; i++) begin
            b = (i == 0) ? 1'b0 : (i > nb) ? 1'b1 : w[i-1];
            @(posedge pclk) rx_out <= b;
            repeat (per / 2 - 1) @(posedge pclk);
            @(posedge pclk) rx_out <= b ^ (i > 0 && i <= nb);
            @(posedge pclk) rx_out <= b;
            repeat (per - per / 2 - 2) @(posedge pclk);
        end
    endtask

    // Slave shifts the next bit out after each rising serial clock edge
    always @(posedge pclk) begin
        sclk_d <= sclk_in;
        if (sclk_in && !sclk_d) begin
            if (nleft == 0) begin
                sh = (sync_q.size() > 0) ? sync_q.pop_front() : ~sh;
                nleft = 8;
            end
            rx_out <= sh[0];
            sh = sh >> 1;
            nleft = nleft - 1;
        end
    end
endmodule // spbr_peer

/* bench/spbr_properties.sv */
`timescale 1ns/1ps
module spbr_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sleep_mode,
    input wire logic rx_data_in,
    input wire logic sclk_out,
    input wire logic sclk_oe,
    input wire logic receive_irq
);
    typedef struct packed {
        logic [7:0] div;
        logic [9:0] hi;
    } spbr_chk_t;
    spbr_chk_t st_ff;
    spbr_chk_t nxt_st;
    wire acc = psel && penable;
    wire pop = acc && !pwrite && paddr == spbr_pkg::ADDR_RECEIVE_DATA;
    wire en_wr = acc && pwrite && paddr == spbr_pkg::ADDR_PERIPHERAL_ENABLES;
    wire mapped = paddr inside {spbr_pkg::ADDR_INTERRUPT_CONTROL,
        spbr_pkg::ADDR_PERIPHERAL_FLAGS, spbr_pkg::ADDR_RECEIVE_STATUS_CONTROL,
        spbr_pkg::ADDR_RECEIVE_DATA, spbr_pkg::ADDR_PERIPHERAL_ENABLES,
        spbr_pkg::ADDR_TRANSMIT_STATUS_CONTROL, spbr_pkg::ADDR_BAUD_DIVISOR};

    // Tracks the divisor software wrote and how long the serial clock stays high
    always_comb begin
        nxt_st = st_ff;
        if (acc && pwrite && pstrb[0] && paddr == spbr_pkg::ADDR_BAUD_DIVISOR) begin
            nxt_st.div = pwdata[7:0];
        end
        nxt_st.hi = sclk_out ? st_ff.hi + 10'h1 : 10'h0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence rd_acc(a);
        psel && penable && !pwrite && paddr == a;
    endsequence

    zero_wait_a: assert property (psel && !penable |=> pready)
        else $error("access phase without ready");
    unmapped_err_a: assert property (acc && !mapped |-> pslverr)
        else $error("unmapped access without error");
    mapped_ok_a: assert property (acc && mapped |-> !pslverr)
        else $error("error on mapped access");
    upper_zero_a: assert property (rd_acc(paddr) |-> prdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    shift_empty_a: assert property (rd_acc(spbr_pkg::ADDR_TRANSMIT_STATUS_CONTROL) |-> prdata[1])
        else $error("shift empty bit reads zero");
    irq_holds_a: assert property (receive_irq && !pop && !en_wr |=> receive_irq)
        else $error("receive request dropped without a data read");
    flag_read_a: assert property (
        rd_acc(spbr_pkg::ADDR_PERIPHERAL_FLAGS) ##0 $past(receive_irq, 2) |-> prdata[5])
        else $error("receive flag low while request pending");
    sclk_high_a: assert property (
        $fell(sclk_out) |-> st_ff.hi == {1'b0, st_ff.div, 1'b0} + 10'h2)
        else $error("serial clock high phase length wrong");
    sleep_freeze_a: assert property (sleep_mode [*3] |-> $stable(sclk_out))
        else $error("serial clock moved while asleep");
    sclk_idle_a: assert property (!sclk_oe ##1 !sclk_oe |-> !sclk_out)
        else $error("serial clock high while not driven");
endmodule // spbr_properties

bind spbr_top spbr_properties u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_mode(sleep_mode), .rx_data_in(rx_data_in),
    .sclk_out(sclk_out), .sclk_oe(sclk_oe), .receive_irq(receive_irq)
);

/* pkg/spbr_pkg.sv */
// Function
// - Baud generator is a free-running 8-bit timer with period set by baud_divisor.
// - high_speed_baud changes the rate in asynchronous mode only.
// - Async rate is clock/(64(X+1)) low speed or clock/(16(X+1)) high speed.
// - Synchronous master rate is clock/(4(X+1)) with no high-speed variant.
// - Any baud_divisor write clears the baud timer at once.
// - Baud timing uses the system clock; no baud ticks while sleeping.
// - Receive pin is sampled three times per bit, majority decides.
// - With ninth_bit_receive_en set, 9-bit words are received, ninth bit in status.
// - A buffered word sets receive_flag; interrupt requested only with receive_irq_en.
// - Synchronous master samples the data line on the falling clock edge.
// - Single receive takes one word, continuous runs until cleared and wins.
// - After the last bit the shift register moves into the buffer if space exists.
// - receive_flag is read-only and clears once the buffer is read empty.
// - Receive buffer is a two-entry FIFO read back in order.
// - Last bit of a word into a full buffer sets overrun_error, word lost.
// - Overrun blocks buffer transfers; clearing continuous_receive_en clears it.
// - Ninth bit is buffered with its byte; each data read loads the next.
package spbr_pkg;

    localparam int CLK_HZ = 50_000_000;

    localparam logic [9:0] IDX_INTERRUPT_CONTROL = 10'h00b;
    localparam logic [9:0] IDX_PERIPHERAL_FLAGS = 10'h00c;
    localparam logic [9:0] IDX_RECEIVE_STATUS_CONTROL = 10'h018;
    localparam logic [9:0] IDX_RECEIVE_DATA = 10'h01a;
    localparam logic [9:0] IDX_PERIPHERAL_ENABLES = 10'h08c;
    localparam logic [9:0] IDX_TRANSMIT_STATUS_CONTROL = 10'h098;
    localparam logic [9:0] IDX_BAUD_DIVISOR = 10'h099;

    localparam logic [11:0] ADDR_INTERRUPT_CONTROL = {IDX_INTERRUPT_CONTROL, 2'b00};
    localparam logic [11:0] ADDR_PERIPHERAL_FLAGS = {IDX_PERIPHERAL_FLAGS, 2'b00};
    localparam logic [11:0] ADDR_RECEIVE_STATUS_CONTROL = {IDX_RECEIVE_STATUS_CONTROL, 2'b00};
    localparam logic [11:0] ADDR_RECEIVE_DATA = {IDX_RECEIVE_DATA, 2'b00};
    localparam logic [11:0] ADDR_PERIPHERAL_ENABLES = {IDX_PERIPHERAL_ENABLES, 2'b00};
    localparam logic [11:0] ADDR_TRANSMIT_STATUS_CONTROL = {IDX_TRANSMIT_STATUS_CONTROL, 2'b00};
    localparam logic [11:0] ADDR_BAUD_DIVISOR = {IDX_BAUD_DIVISOR, 2'b00};

    localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
    localparam logic [7:0] RST_PERIPHERAL_ENABLES = 8'h00;
    localparam logic [7:0] RST_RECEIVE_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] RST_TRANSMIT_STATUS_CONTROL = 8'h02;
    localparam logic [7:0] RST_BAUD_DIVISOR = 8'h00;

    localparam logic [7:0] MASK_INTERRUPT_CONTROL = 8'hff;
    localparam logic [7:0] MASK_PERIPHERAL_ENABLES = 8'h7f;
    localparam logic [7:0] MASK_RECEIVE_STATUS_CONTROL = 8'hf8;
    localparam logic [7:0] MASK_TRANSMIT_STATUS_CONTROL = 8'hf5;

    // receive_status_control bits
    localparam int BIT_PORT_ENABLE = 7;
    localparam int BIT_NINTH_BIT_RECEIVE_EN = 6;
    localparam int BIT_SINGLE_RECEIVE_EN = 5;
    localparam int BIT_CONTINUOUS_RECEIVE_EN = 4;
    // transmit_status_control bits
    localparam int BIT_MASTER_CLOCK_SOURCE = 7;
    localparam int BIT_SYNC_MODE = 4;
    localparam int BIT_HIGH_SPEED_BAUD = 2;
    localparam int BIT_SHIFT_EMPTY = 1;
    // peripheral_flags and peripheral_enables bit
    localparam int BIT_RECEIVE_FLAG = 5;

    // Async: 16 sub-samples per bit, low speed adds a divide by 4
    localparam logic [3:0] SUB_LAST = 4'hf;
    localparam logic [3:0] SUB_VOTE_A = 4'h7;
    localparam logic [3:0] SUB_VOTE_B = 4'h8;
    localparam logic [3:0] SUB_DECIDE = 4'h9;
    localparam logic [1:0] LOW_SPEED_PRESC_LAST = 2'h3;
    // Sync: four baud ticks per bit, clock high in phases 0 and 1
    localparam logic [1:0] SYNC_PHASE_BEFORE_FALL = 2'h1;
    localparam logic [3:0] LAST_BIT_8 = 4'h7;
    localparam logic [3:0] LAST_BIT_9 = 4'h8;
    localparam logic [1:0] FIFO_FULL = 2'h2;

endpackage

/* src/spbr_baud_gen.sv */
`timescale 1ns/1ps
module spbr_baud_gen (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic run,
    input wire logic [7:0] divisor,
    output logic tick
);

    typedef struct packed {
        logic [7:0] count;
    } spbr_baud_state_t;

    spbr_baud_state_t st_ff;
    spbr_baud_state_t nxt_st;

    assign tick = run && (st_ff.count == divisor);

    always_comb begin
        nxt_st = st_ff;
        if (clear) begin
            nxt_st.count = 8'h00;
        end else if (run) begin
            if (tick) begin
                nxt_st.count = 8'h00;
            end else begin
                nxt_st.count = st_ff.count + 8'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule // spbr_baud_gen

/* src/spbr_top.sv */
// Local design decision: the APB register port.
`timescale 1ns/1ps
module spbr_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_mode,
    input wire logic rx_data_in,
    output logic sclk_out,
    output logic sclk_oe,
    output logic receive_irq
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_STOP,
        ST_SYNC
    } spbr_rx_state_t;

    typedef struct packed {
        logic [7:0] intctl;
        logic [7:0] pie;
        logic [7:0] receive_status_control;
        logic [7:0] transmit_status_control;
        logic [7:0] divisor;
        logic [1:0][9:0] fifo;
        logic rd_ptr;
        logic [1:0] count;
        logic overrun;
        spbr_rx_state_t state;
        logic [3:0] sub;
        logic [1:0] presc;
        logic [3:0] bits;
        logic [8:0] shift;
        logic [1:0] vote;
        logic [2:0] hist;
        logic [1:0] phase;
        logic sclk;
        logic [31:0] prdata;
        logic pslverr;
        logic pop_ok;
    } spbr_state_t;

    spbr_state_t st_ff;
    spbr_state_t nxt_st;

    logic baud_tick;
    logic baud_clear;
    logic baud_run;
    logic wr_en;

    function automatic logic maj3(input logic a, input logic b, input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction

    assign wr_en = psel && penable && pwrite && pstrb[0];
    assign baud_clear = wr_en && (paddr == spbr_pkg::ADDR_BAUD_DIVISOR);
    assign baud_run = !sleep_mode && st_ff.receive_status_control[spbr_pkg::BIT_PORT_ENABLE];

    spbr_baud_gen u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .clear(baud_clear),
        .run(baud_run),
        .divisor(st_ff.divisor),
        .tick(baud_tick)
    );

    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign prdata = st_ff.prdata;
    assign pslverr = st_ff.pslverr;
    assign sclk_out = st_ff.sclk;
    assign sclk_oe = st_ff.receive_status_control[spbr_pkg::BIT_PORT_ENABLE]
        && st_ff.transmit_status_control[spbr_pkg::BIT_SYNC_MODE]
        && st_ff.transmit_status_control[spbr_pkg::BIT_MASTER_CLOCK_SOURCE];
    assign receive_irq = (st_ff.count != 2'h0)
        && st_ff.pie[spbr_pkg::BIT_RECEIVE_FLAG];

    always_comb begin
        logic [7:0] rdv;
        logic hit;
        logic [9:0] head;
        logic [9:0] word;
        logic [8:0] shifted;
        logic [3:0] last_bit;
        logic done;
        logic bitv;
        logic pop;
        logic push;
        logic sample;
        logic port_enable;
        logic sync;
        logic rx9;
        logic continuous_receive_en;
        logic sync_go;
        logic wslot;
        logic fifo_ne;
        rdv = 8'h00;
        hit = 1'b1;
        head = st_ff.fifo[st_ff.rd_ptr];
        word = 10'h000;
        shifted = 9'h000;
        done = 1'b0;
        bitv = 1'b0;
        push = 1'b0;
        sample = 1'b0;
        wslot = 1'b0;
        pop = 1'b0;
        fifo_ne = (st_ff.count != 2'h0);
        nxt_st = st_ff;
        port_enable = st_ff.receive_status_control[spbr_pkg::BIT_PORT_ENABLE];
        sync = st_ff.transmit_status_control[spbr_pkg::BIT_SYNC_MODE];
        rx9 = st_ff.receive_status_control[spbr_pkg::BIT_NINTH_BIT_RECEIVE_EN];
        continuous_receive_en = st_ff.receive_status_control[spbr_pkg::BIT_CONTINUOUS_RECEIVE_EN];
        last_bit = rx9 ? spbr_pkg::LAST_BIT_9 : spbr_pkg::LAST_BIT_8;
        sync_go = port_enable && sync && st_ff.transmit_status_control[spbr_pkg::BIT_MASTER_CLOCK_SOURCE]
            && (continuous_receive_en || st_ff.receive_status_control[spbr_pkg::BIT_SINGLE_RECEIVE_EN])
            && !st_ff.overrun;

        // Register writes
        if (wr_en) begin
            case (paddr)
                spbr_pkg::ADDR_INTERRUPT_CONTROL: begin
                    nxt_st.intctl = pwdata[7:0] & spbr_pkg::MASK_INTERRUPT_CONTROL;
                end
                spbr_pkg::ADDR_PERIPHERAL_ENABLES: begin
                    nxt_st.pie = pwdata[7:0] & spbr_pkg::MASK_PERIPHERAL_ENABLES;
                end
                spbr_pkg::ADDR_RECEIVE_STATUS_CONTROL: begin
                    nxt_st.receive_status_control = pwdata[7:0] & spbr_pkg::MASK_RECEIVE_STATUS_CONTROL;
                    if (!pwdata[spbr_pkg::BIT_CONTINUOUS_RECEIVE_EN]) begin
                        nxt_st.overrun = 1'b0;
                    end
                end
                spbr_pkg::ADDR_TRANSMIT_STATUS_CONTROL: begin
                    nxt_st.transmit_status_control = pwdata[7:0] & spbr_pkg::MASK_TRANSMIT_STATUS_CONTROL;
                end
                spbr_pkg::ADDR_BAUD_DIVISOR: begin
                    nxt_st.divisor = pwdata[7:0];
                end
                default: begin
                end
            endcase
        end

        // Read data is captured in the setup cycle
        case (paddr)
            spbr_pkg::ADDR_INTERRUPT_CONTROL: begin
                rdv = st_ff.intctl;
            end
            spbr_pkg::ADDR_PERIPHERAL_FLAGS: begin
                rdv[spbr_pkg::BIT_RECEIVE_FLAG] = fifo_ne;
            end
            spbr_pkg::ADDR_RECEIVE_STATUS_CONTROL: begin
                rdv = st_ff.receive_status_control;
                if (fifo_ne) begin
                    rdv[2] = head[9];
                    rdv[0] = head[8];
                end
                rdv[1] = st_ff.overrun;
            end
            spbr_pkg::ADDR_RECEIVE_DATA: begin
                rdv = head[7:0];
            end
            spbr_pkg::ADDR_PERIPHERAL_ENABLES: begin
                rdv = st_ff.pie;
            end
            spbr_pkg::ADDR_TRANSMIT_STATUS_CONTROL: begin
                rdv = st_ff.transmit_status_control;
                rdv[spbr_pkg::BIT_SHIFT_EMPTY] = 1'b1;
            end
            spbr_pkg::ADDR_BAUD_DIVISOR: begin
                rdv = st_ff.divisor;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        if (psel && !penable) begin
            nxt_st.prdata = {24'h000000, rdv};
            nxt_st.pslverr = !hit;
            nxt_st.pop_ok = hit && !pwrite && (paddr == spbr_pkg::ADDR_RECEIVE_DATA)
                && fifo_ne;
        end
        // Pop only a word that was present at setup, so prdata and the pop agree
        pop = psel && penable && !pwrite && st_ff.pop_ok;

        // Three most recent pin levels, for the synchronous vote
        nxt_st.hist = {st_ff.hist[1:0], rx_data_in};

        // Async sub-sample tick: 16 per bit, prescaled by 4 at low speed
        if (baud_tick && !sync) begin
            if (st_ff.transmit_status_control[spbr_pkg::BIT_HIGH_SPEED_BAUD]) begin
                sample = 1'b1;
            end else begin
                nxt_st.presc = st_ff.presc + 2'h1;
                sample = (st_ff.presc == spbr_pkg::LOW_SPEED_PRESC_LAST);
            end
        end
        bitv = maj3(st_ff.vote[1], st_ff.vote[0], rx_data_in);

        unique case (st_ff.state)
            ST_IDLE: begin
                nxt_st.bits = 4'h0;
                // Park in the last low phase so the first rising edge waits for a baud tick
                nxt_st.phase = 2'h3;
                if (sync_go) begin
                    nxt_st.state = ST_SYNC;
                end else if (port_enable && !sync && continuous_receive_en && sample && !rx_data_in) begin
                    nxt_st.state = ST_START;
                    nxt_st.sub = 4'h0;
                end
            end
            ST_START, ST_DATA, ST_STOP: begin
                if (sample) begin
                    nxt_st.sub = st_ff.sub + 4'h1;
                    if (st_ff.sub == spbr_pkg::SUB_VOTE_A
                        || st_ff.sub == spbr_pkg::SUB_VOTE_B) begin
                        nxt_st.vote = {st_ff.vote[0], rx_data_in};
                    end
                    if (st_ff.sub == spbr_pkg::SUB_DECIDE) begin
                        if (st_ff.state == ST_START && bitv) begin
                            nxt_st.state = ST_IDLE;
                        end else if (st_ff.state == ST_DATA) begin
                            nxt_st.shift = {bitv, st_ff.shift[8:1]};
                        end else if (st_ff.state == ST_STOP) begin
                            done = 1'b1;
                            word[9] = !bitv;
                            nxt_st.state = ST_IDLE;
                        end
                    end
                    if (st_ff.sub == spbr_pkg::SUB_LAST) begin
                        if (st_ff.state == ST_START) begin
                            nxt_st.state = ST_DATA;
                        end else if (st_ff.bits == last_bit) begin
                            nxt_st.state = ST_STOP;
                        end else begin
                            nxt_st.bits = st_ff.bits + 4'h1;
                        end
                    end
                end
                if (!port_enable || !continuous_receive_en || sync) begin
                    nxt_st.state = ST_IDLE;
                    done = 1'b0;
                end
            end
            ST_SYNC: begin
                if (!sync_go) begin
                    nxt_st.state = ST_IDLE;
                end else if (baud_tick) begin
                    nxt_st.phase = st_ff.phase + 2'h1;
                    if (st_ff.phase == spbr_pkg::SYNC_PHASE_BEFORE_FALL) begin
                        bitv = maj3(st_ff.hist[2], st_ff.hist[1], st_ff.hist[0]);
                        shifted = {bitv, st_ff.shift[8:1]};
                        nxt_st.shift = shifted;
                        if (st_ff.bits == last_bit) begin
                            done = 1'b1;
                            nxt_st.bits = 4'h0;
                            if (!continuous_receive_en) begin
                                nxt_st.receive_status_control[spbr_pkg::BIT_SINGLE_RECEIVE_EN] = 1'b0;
                            end
                        end else begin
                            nxt_st.bits = st_ff.bits + 4'h1;
                        end
                    end
                end
            end
        endcase

        // Assemble the finished word from the shift register
        if (st_ff.state != ST_SYNC) begin
            shifted = st_ff.shift;
        end
        if (rx9) begin
            word[8:0] = shifted;
        end else begin
            word[7:0] = shifted[8:1];
        end

        // Buffer transfer, overrun and FIFO bookkeeping
        // A word completing into a full buffer with no pop that cycle is dropped; the overrun set beats its clear
        if (done) begin
            if (st_ff.overrun) begin
                push = 1'b0;
            end else if (st_ff.count == spbr_pkg::FIFO_FULL && !pop) begin
                nxt_st.overrun = 1'b1;
            end else begin
                push = 1'b1;
            end
        end
        if (push) begin
            // Tail slot; with a full buffer, a pop in the same cycle frees the head slot that gets refilled
            wslot = st_ff.rd_ptr ^ st_ff.count[0];
            nxt_st.fifo[wslot] = word;
        end
        if (pop) begin
            nxt_st.rd_ptr = !st_ff.rd_ptr;
        end
        case ({push, pop})
            2'b10: begin
                nxt_st.count = st_ff.count + 2'h1;
            end
            2'b01: begin
                nxt_st.count = st_ff.count - 2'h1;
            end
            default: begin
            end
        endcase

        if (baud_clear) begin
            nxt_st.presc = 2'h0;
        end

        // Serial clock: high for the first half of each bit
        nxt_st.sclk = (nxt_st.state == ST_SYNC) && !nxt_st.phase[1];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
            st_ff.intctl <= spbr_pkg::RST_INTERRUPT_CONTROL;
            st_ff.pie <= spbr_pkg::RST_PERIPHERAL_ENABLES;
            st_ff.receive_status_control <= spbr_pkg::RST_RECEIVE_STATUS_CONTROL;
            st_ff.transmit_status_control <= spbr_pkg::RST_TRANSMIT_STATUS_CONTROL
                & spbr_pkg::MASK_TRANSMIT_STATUS_CONTROL;
            st_ff.divisor <= spbr_pkg::RST_BAUD_DIVISOR;
            st_ff.state <= ST_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule // spbr_top
